// ===== verilog/sess_defines.svh
// Constants for the sector erase suspend sequencer host controller.
// Assumes a 200 MHz clock and a parallel NOR flash on the far side.
`ifndef SESS_DEFINES_SVH
`define SESS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Host register map
// ----------------------------------------------------------------------------
`define SESS_REG_CMD      4'h0
`define SESS_REG_ADDR     4'h1
`define SESS_REG_DATA     4'h2
`define SESS_REG_STATUS   4'h3
`define SESS_REG_RDATA    4'h4
`define SESS_REG_CFG      4'h5

// ----------------------------------------------------------------------------
// Host command codes written to the command register
// ----------------------------------------------------------------------------
`define SESS_OP_SERASE    4'h1
`define SESS_OP_ADDSEC    4'h2
`define SESS_OP_SUSPEND   4'h3
`define SESS_OP_RESUME    4'h4
`define SESS_OP_RESET     4'h5
`define SESS_OP_PROGRAM   4'h6
`define SESS_OP_AUTOSEL   4'h7
`define SESS_OP_READ      4'h8

// ----------------------------------------------------------------------------
// Flash command data and unlock addresses
// ----------------------------------------------------------------------------
`define SESS_D_UNLOCK1    8'haa
`define SESS_D_UNLOCK2    8'h55
`define SESS_D_SETUP      8'h80
`define SESS_D_SECTOR     8'h30
`define SESS_D_SUSPEND    8'hb0
`define SESS_D_RESUME     8'h30
`define SESS_D_RESET      8'hf0
`define SESS_D_PROGRAM    8'ha0
`define SESS_D_AUTOSEL    8'h90
`define SESS_A_W1         17'h00555
`define SESS_A_W2         17'h002aa
`define SESS_A_B1         17'h00aaa
`define SESS_A_B2         17'h00555

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SESS_CLK_MHZ      200
`define SESS_TIMEOUT_US   50
// Longest gap that still lands inside the time-out: rounded down, with margin halved.
`define SESS_GAP_CYC      ((`SESS_TIMEOUT_US * `SESS_CLK_MHZ) / 2)
`define SESS_PULSE_CYC    4'h8
`define SESS_CFG_BYTE_BIT 0

`endif

// ===== verilog/sess_pkg.sv
// Types for the sector erase suspend sequencer host controller.
// Assumes sess_defines.svh is compiled alongside.
package sess_pkg;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  data;
    logic        rd;
  } sess_cyc_t;

  typedef enum logic [6:0] {
    SESS_IDLE  = 7'b0000001,
    SESS_LOAD  = 7'b0000010,
    SESS_SETUP = 7'b0000100,
    SESS_ACT   = 7'b0001000,
    SESS_HOLD  = 7'b0010000,
    SESS_GAP   = 7'b0100000,
    SESS_DONE  = 7'b1000000
  } sess_state_t;

endpackage

// ===== verilog/sess_bus_cycle.sv
// One flash bus cycle: write or read pulse on the chip and strobe pins.
// Assumes the flash accepts a write on the rising edge of the write strobe.
`timescale 1ns/1ps
`include "sess_defines.svh"

module sess_bus_cycle (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire sess_pkg::sess_cyc_t cyc_i,
  input  wire logic [15:0]       dq_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [15:0]            rdata_o,
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o,
  output logic [16:0]            addr_o,
  output logic [15:0]            dq_o,
  output logic                   dq_oe_o
);

  logic [3:0]  cnt_ff, nxt_cnt;
  logic        busy_ff, nxt_busy;
  logic        done_ff, nxt_done;
  logic        rd_ff, nxt_rd;
  logic [16:0] addr_ff, nxt_addr;
  logic [15:0] dq_ff, nxt_dq;
  logic [15:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_busy  = busy_ff;
    nxt_done  = 1'b0;
    nxt_rd    = rd_ff;
    nxt_addr  = addr_ff;
    nxt_dq    = dq_ff;
    nxt_rdata = rdata_ff;
    if (!busy_ff && start_i) begin
      nxt_busy = 1'b1;
      nxt_cnt  = `SESS_PULSE_CYC;
      nxt_rd   = cyc_i.rd;
      nxt_addr = cyc_i.addr;
      nxt_dq   = {8'h00, cyc_i.data};
    end else if (busy_ff) begin
      if (cnt_ff == 4'h0) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        if (rd_ff) begin
          nxt_rdata = dq_i;
        end
      end else begin
        nxt_cnt = cnt_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff   <= 4'h0;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      rd_ff    <= 1'b0;
      addr_ff  <= 17'h00000;
      dq_ff    <= 16'h0000;
      rdata_ff <= 16'h0000;
    end else begin
      cnt_ff   <= nxt_cnt;
      busy_ff  <= nxt_busy;
      done_ff  <= nxt_done;
      rd_ff    <= nxt_rd;
      addr_ff  <= nxt_addr;
      dq_ff    <= nxt_dq;
      rdata_ff <= nxt_rdata;
    end
  end

  // The strobe drops when the count reaches zero, one cycle before busy ends, so address and data hold past it.
  logic strobe;
  assign strobe = busy_ff && (cnt_ff != 4'h0) && (cnt_ff != `SESS_PULSE_CYC);

  logic ce_n_ff, we_n_ff, oe_n_ff, oe_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      oe_ff   <= 1'b0;
    end else begin
      ce_n_ff <= !busy_ff;
      we_n_ff <= !(strobe && !rd_ff);
      oe_n_ff <= !(busy_ff && rd_ff);
      oe_ff   <= busy_ff && !rd_ff;
    end
  end

  assign busy_o  = busy_ff;
  assign done_o  = done_ff;
  assign rdata_o = rdata_ff;
  assign ce_n_o  = ce_n_ff;
  assign we_n_o  = we_n_ff;
  assign oe_n_o  = oe_n_ff;
  assign addr_o  = addr_ff;
  assign dq_o    = dq_ff;
  assign dq_oe_o = oe_ff;

endmodule

// ===== verilog/sess_host.sv
// Host controller that drives sector erase, suspend, resume and related commands.
// Assumes a register master with one-cycle strobes and one flash on the pins.
//
// Contract
// - Sector erase uses six unlock and command writes.
// - Added sector pairs sent within the time-out.
// - Software masks interrupts while adding sectors.
// - Other command in time-out forces full rewrite.
// - Hardware reset aborts erase; reissue afterwards.
// - Program is two unlocks, A0, then address/value.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "sess_defines.svh"

module sess_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_n_i,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o,
  output logic             flash_reset_n_o,
  output logic [16:0]      addr_o,
  output logic [15:0]      dq_o,
  output logic             dq_oe_o
);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [16:0] addr_ff, nxt_addr;
  logic [7:0]  data_ff, nxt_data;
  logic        byte_ff, nxt_byte;
  logic [3:0]  op_ff, nxt_op;
  logic        go_ff, nxt_go;
  logic        err_ff, nxt_err;
  logic        susp_ff, nxt_susp;
  logic        erase_ff, nxt_erase;
  logic        tmo_ff, nxt_tmo;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [15:0] rd_val;
  logic        cyc_done;

  sess_pkg::sess_state_t state_ff, nxt_state;
  logic [2:0]  idx_ff, nxt_idx;
  logic [2:0]  len_ff, nxt_len;
  logic [13:0] gap_ff, nxt_gap;
  logic        start_ff, nxt_start;
  sess_pkg::sess_cyc_t cyc_ff, nxt_cyc;

  logic accept;
  logic busy;
  assign busy   = (state_ff != sess_pkg::SESS_IDLE) || go_ff;
  assign accept = reg_wr_i && (reg_addr_i == `SESS_REG_CMD) && !busy;

  always_comb begin
    nxt_addr  = addr_ff;
    nxt_data  = data_ff;
    nxt_byte  = byte_ff;
    nxt_op    = op_ff;
    nxt_go    = 1'b0;
    nxt_rdata = 32'h00000000;
    if (reg_wr_i) begin
      if (reg_addr_i == `SESS_REG_ADDR) begin
        nxt_addr = reg_wdata_i[16:0];
      end else if (reg_addr_i == `SESS_REG_DATA) begin
        nxt_data = reg_wdata_i[7:0];
      end else if (reg_addr_i == `SESS_REG_CFG) begin
        nxt_byte = reg_wdata_i[`SESS_CFG_BYTE_BIT];
      end else if (accept) begin
        nxt_op = reg_wdata_i[3:0];
        nxt_go = 1'b1;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `SESS_REG_ADDR) begin
        nxt_rdata = {15'h0000, addr_ff};
      end else if (reg_addr_i == `SESS_REG_DATA) begin
        nxt_rdata = {24'h000000, data_ff};
      end else if (reg_addr_i == `SESS_REG_CFG) begin
        nxt_rdata = {31'h00000000, byte_ff};
      end else if (reg_addr_i == `SESS_REG_STATUS) begin
        // Bits: busy, device busy, erasing, suspended, gap expired, refused.
        nxt_rdata = {26'h0000000, err_ff, tmo_ff, susp_ff, erase_ff, !ready_busy_n_i, busy};
      end else if (reg_addr_i == `SESS_REG_RDATA) begin
        nxt_rdata = {16'h0000, rd_val};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff  <= 17'h00000;
      data_ff  <= 8'h00;
      byte_ff  <= 1'b0;
      op_ff    <= 4'h0;
      go_ff    <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      addr_ff  <= nxt_addr;
      data_ff  <= nxt_data;
      byte_ff  <= nxt_byte;
      op_ff    <= nxt_op;
      go_ff    <= nxt_go;
      rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  // Builds the flash bus cycle for step idx of the current operation.
  function automatic sess_pkg::sess_cyc_t step_cyc(input logic [3:0] op, input logic [2:0] idx,
                                                   input logic bm, input logic [16:0] a,
                                                   input logic [7:0] d);
    sess_pkg::sess_cyc_t c;
    logic [16:0] u1;
    logic [16:0] u2;
    c  = '0;
    u1 = bm ? `SESS_A_B1 : `SESS_A_W1;
    u2 = bm ? `SESS_A_B2 : `SESS_A_W2;
    c.addr = (idx[0] == 1'b0) ? u1 : u2;
    c.data = (idx[0] == 1'b0) ? `SESS_D_UNLOCK1 : `SESS_D_UNLOCK2;
    if (idx == 3'h2) begin
      c.addr = u1;
      if (op == `SESS_OP_SERASE) begin
        c.data = `SESS_D_SETUP;
      end else if (op == `SESS_OP_PROGRAM) begin
        c.data = `SESS_D_PROGRAM;
      end else begin
        c.data = `SESS_D_AUTOSEL;
      end
    end else if (idx == 3'h3 && op == `SESS_OP_PROGRAM) begin
      c.addr = a;
      c.data = d;
    end else if (idx == 3'h3) begin
      c.addr = u1;
      c.data = `SESS_D_UNLOCK1;
    end else if (idx == 3'h4) begin
      c.addr = u2;
      c.data = `SESS_D_UNLOCK2;
    end else if (idx == 3'h5) begin
      c.addr = a;
      c.data = `SESS_D_SECTOR;
    end
    if (op == `SESS_OP_ADDSEC) begin
      // The whole pair goes out from one command, so no interrupt can split it.
      c.addr = a;
      c.data = `SESS_D_SECTOR;
    end else if (op == `SESS_OP_SUSPEND) begin
      c.data = `SESS_D_SUSPEND;
    end else if (op == `SESS_OP_RESUME) begin
      c.data = `SESS_D_RESUME;
    end else if (op == `SESS_OP_RESET) begin
      c.data = `SESS_D_RESET;
    end else if (op == `SESS_OP_READ) begin
      c.addr = a;
      c.rd   = 1'b1;
    end
    return c;
  endfunction

  // Command legality against the host's view of the erase; refusal keeps the device out of bad states.
  logic legal;
  always_comb begin
    legal = 1'b1;
    if (nxt_op == `SESS_OP_ADDSEC) begin
      legal = erase_ff && !tmo_ff && !susp_ff;
    end else if (nxt_op == `SESS_OP_SUSPEND) begin
      legal = erase_ff && !susp_ff;
    end else if (nxt_op == `SESS_OP_RESUME) begin
      legal = susp_ff;
    end else if (nxt_op == `SESS_OP_SERASE) begin
      legal = !erase_ff;
    end else if (nxt_op == `SESS_OP_PROGRAM || nxt_op == `SESS_OP_AUTOSEL) begin
      legal = !erase_ff || susp_ff;
    end else if (nxt_op == `SESS_OP_RESET) begin
      legal = !erase_ff || susp_ff || !tmo_ff;
    end else if (nxt_op != `SESS_OP_READ) begin
      legal = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_len   = len_ff;
    nxt_start = 1'b0;
    nxt_cyc   = cyc_ff;
    nxt_err   = err_ff;
    nxt_susp  = susp_ff;
    nxt_erase = erase_ff;
    nxt_tmo   = tmo_ff;
    nxt_gap   = gap_ff;
    // The gap counter runs from the last erase-related strobe.
    if (erase_ff && !susp_ff && gap_ff != 14'h0000) begin
      nxt_gap = gap_ff - 14'h0001;
    end else if (erase_ff && !susp_ff) begin
      nxt_tmo = 1'b1;
    end
    // A finished erase reads as ready after the time-out; the device then sits in array read.
    if (erase_ff && tmo_ff && !susp_ff && ready_busy_n_i && state_ff == sess_pkg::SESS_IDLE) begin
      nxt_erase = 1'b0;
    end
    case (state_ff)
      sess_pkg::SESS_IDLE: begin
        if (go_ff) begin
          nxt_err = !legal;
          if (legal) begin
            nxt_state = sess_pkg::SESS_LOAD;
            nxt_idx   = 3'h0;
            if (op_ff == `SESS_OP_SERASE) begin
              nxt_len = 3'h5;
            end else if (op_ff == `SESS_OP_PROGRAM || op_ff == `SESS_OP_AUTOSEL) begin
              nxt_len = (op_ff == `SESS_OP_PROGRAM) ? 3'h3 : 3'h2;
            end else begin
              nxt_len = 3'h0;
            end
          end
        end
      end
      sess_pkg::SESS_LOAD: begin
        nxt_cyc   = step_cyc(((len_ff == 3'h0) ? op_ff : op_ff), idx_ff, byte_ff, addr_ff, data_ff);
        nxt_start = 1'b1;
        nxt_state = sess_pkg::SESS_ACT;
      end
      sess_pkg::SESS_ACT: begin
        if (cyc_done) begin
          if (idx_ff == len_ff) begin
            nxt_state = sess_pkg::SESS_DONE;
          end else begin
            nxt_idx   = idx_ff + 3'h1;
            nxt_state = sess_pkg::SESS_LOAD;
          end
        end
      end
      sess_pkg::SESS_DONE: begin
        nxt_state = sess_pkg::SESS_IDLE;
        if (op_ff == `SESS_OP_SERASE || op_ff == `SESS_OP_ADDSEC) begin
          nxt_erase = 1'b1;
          nxt_tmo   = 1'b0;
          nxt_gap   = 14'(`SESS_GAP_CYC);
        end else if (op_ff == `SESS_OP_SUSPEND) begin
          nxt_susp = 1'b1;
        end else if (op_ff == `SESS_OP_RESUME) begin
          nxt_susp = 1'b0;
          nxt_tmo  = 1'b1;
        end else if (op_ff == `SESS_OP_RESET && !susp_ff) begin
          nxt_erase = 1'b0;
        end
      end
      default: begin
        nxt_state = sess_pkg::SESS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= sess_pkg::SESS_IDLE;
      idx_ff   <= 3'h0;
      len_ff   <= 3'h0;
      start_ff <= 1'b0;
      cyc_ff   <= '0;
      err_ff   <= 1'b0;
      susp_ff  <= 1'b0;
      erase_ff <= 1'b0;
      tmo_ff   <= 1'b0;
      gap_ff   <= 14'h0000;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      len_ff   <= nxt_len;
      start_ff <= nxt_start;
      cyc_ff   <= nxt_cyc;
      err_ff   <= nxt_err;
      susp_ff  <= nxt_susp;
      erase_ff <= nxt_erase;
      tmo_ff   <= nxt_tmo;
      gap_ff   <= nxt_gap;
    end
  end

  // Hardware reset of the flash follows the host reset, so an erase aborts with it.
  logic frst_n_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frst_n_ff <= 1'b0;
    end else begin
      frst_n_ff <= 1'b1;
    end
  end

  sess_bus_cycle u_cyc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start_ff),
    .cyc_i   (cyc_ff),
    .dq_i    (dq_i),
    .busy_o  (),
    .done_o  (cyc_done),
    .rdata_o (rd_val),
    .ce_n_o  (ce_n_o),
    .we_n_o  (we_n_o),
    .oe_n_o  (oe_n_o),
    .addr_o  (addr_o),
    .dq_o    (dq_o),
    .dq_oe_o (dq_oe_o)
  );

  assign reg_rdata_o     = rdata_ff;
  assign flash_reset_n_o = frst_n_ff;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_erase_done;
    state_ff == sess_pkg::SESS_DONE && op_ff == `SESS_OP_SERASE;
  endsequence

  a_erase_arms_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    s_erase_done |=> erase_ff && !tmo_ff && gap_ff == 14'(`SESS_GAP_CYC))
    else $error("erase did not arm the time-out");
  a_suspend_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == sess_pkg::SESS_DONE && op_ff == `SESS_OP_SUSPEND) |-> erase_ff)
    else $error("suspend sent outside sector erase");
  a_no_cmd_erasing: assert property (@(posedge clk_i) disable iff (rst_i)
    (go_ff && erase_ff && tmo_ff && !susp_ff && op_ff == `SESS_OP_PROGRAM) |=> err_ff)
    else $error("program accepted during active erase");
  a_resume_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == sess_pkg::SESS_DONE && op_ff == `SESS_OP_RESUME) |=> !susp_ff)
    else $error("resume did not clear suspend");
  a_sixth_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == sess_pkg::SESS_LOAD && op_ff == `SESS_OP_SERASE && idx_ff == 3'h5)
      |=> cyc_ff.data == `SESS_D_SECTOR && cyc_ff.addr == addr_ff)
    else $error("sixth erase write wrong");
  a_setup_third: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == sess_pkg::SESS_LOAD && op_ff == `SESS_OP_PROGRAM && idx_ff == 3'h2)
      |=> cyc_ff.data == `SESS_D_PROGRAM)
    else $error("program setup write wrong");
  a_reset_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == sess_pkg::SESS_LOAD && op_ff == `SESS_OP_RESET) |=> cyc_ff.data == `SESS_D_RESET)
    else $error("reset write wrong");
  a_addsec_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (go_ff && op_ff == `SESS_OP_ADDSEC && tmo_ff) |=> err_ff && state_ff == sess_pkg::SESS_IDLE)
    else $error("late added sector not refused");
  a_flash_reset: assert property (@(posedge clk_i)
    rst_i |=> !flash_reset_n_o)
    else $error("flash reset not driven");

endmodule

// ===== verif/sess_flash_model.sv
// Behavioural parallel NOR flash standing on the host controller's pins.
// Assumes writes land on the rising write strobe, reads follow the output enable, times in ns.
`timescale 1ns/1ps
module sess_flash_model #(
  parameter int          TO_NS  = 50000,
  parameter int          ER_NS  = 20000,
  parameter int          SUS_NS = 1000,
  parameter int          PG_NS  = 500,
  // The identity value is arbitrary.
  parameter logic [15:0] MAKER  = 16'h00c3
) (
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        reset_n_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  output logic             ready_busy_n_o
);
  // Mode: 0 read, 1 time-out, 2 erasing, 3 suspended, 4 programming, 5 autoselect, 6 suspending.
  int          mode  = 0;
  int          seq   = 0;
  bit          sus   = 0;
  bit          tog   = 0;
  time         t_end = 0;
  time         rem   = 0;
  logic [16:0] u1    = 17'h00555;
  logic [31:0] smask = 32'h0;
  logic [15:0] mem [int];
  wire  logic [7:0]  d  = dq_i[7:0];
  wire  logic [16:0] u2 = (u1 == 17'h00aaa) ? 17'h00555 : 17'h002aa;
  initial dq_o = 16'h0000;
  assign ready_busy_n_o = !(mode inside {1, 2, 4, 6});
  // ------------------------------------------------------------
  // Command decoding
  // ------------------------------------------------------------
  always @(posedge we_n_i) begin
    if (!ce_n_i && reset_n_i) begin
      if (mode == 2 && d == 8'hb0) begin
        rem = t_end - $time;
        t_end = $time + SUS_NS;
        mode = 6;
      end else if (mode == 1) begin
        if (d == 8'h30) begin
          smask[addr_i[16:12]] = 1'b1;
          t_end = $time + TO_NS;
        end else if (d == 8'hb0) begin
          rem = ER_NS;
          sus = 1;
          mode = 3;
        end else begin
          mode = 0;
          smask = 32'h0;
        end
      end else if (mode == 5) begin
        if (d == 8'hf0) mode = sus ? 3 : 0;
      end else if (mode == 3 && seq == 0 && d == 8'h30) begin
        t_end = $time + rem;
        sus = 0;
        mode = 2;
      end else if (mode == 0 || mode == 3) begin
        if (seq == 6) begin
          mem[addr_i] = dq_i;
          t_end = $time + PG_NS;
          mode = 4;
          seq = 0;
        end else if (seq == 0 && d == 8'haa && addr_i inside {17'h00555, 17'h00aaa}) begin
          u1 = addr_i;
          seq = 1;
        end else if (seq == 5 && d == 8'h30) begin
          smask[addr_i[16:12]] = 1'b1;
          t_end = $time + TO_NS;
          mode = 1;
          seq = 0;
        end else if (seq == 2 && addr_i == u1 && d inside {8'h80, 8'ha0, 8'h90}) begin
          seq = (d == 8'h80 && !sus) ? 3 : (d == 8'ha0) ? 6 : 0;
          if (d == 8'h90) mode = 5;
        end else if (seq inside {1, 3, 4} && addr_i == ((seq == 3) ? u1 : u2) && d == ((seq == 3) ? 8'haa : 8'h55)) begin
          seq = seq + 1;
        end else begin
          seq = 0;
        end
      end
    end
  end
  // Preprogramming is folded into the erase time, so the host sees no extra step.
  always #5 begin
    if (mode inside {1, 2, 4, 6} && $time >= t_end) begin
      if (mode == 1) t_end = $time + ER_NS;
      if (mode == 6) sus = 1;
      mode = (mode == 1) ? 2 : (mode == 6 || sus) ? 3 : 0;
    end
  end
  always @(negedge reset_n_i) begin
    mode = 0;
    seq = 0;
    sus = 0;
    smask = 32'h0;
  end
  // Released lines show the inverse of the last value, so a stale sample cannot pass.
  always @(oe_n_i) begin
    if (!oe_n_i) begin
      tog = !tog;
      if (mode == 5) dq_o = (addr_i[7:0] == 8'h00) ? MAKER : 16'h0000;
      else if (mode inside {1, 2, 4, 6} || (mode == 3 && smask[addr_i[16:12]])) dq_o = {8'h00, mode == 3, tog & (mode != 3), 2'b00, mode != 1, 3'b000};
      else dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
    end else begin
      dq_o = ~dq_o;
    end
  end
endmodule

// ===== verif/sess_host_bench.sv
// Self-checking bench for the flash host controller with a flash model on its pins.
// Assumes sess_defines.svh on the include path; register reads answer one cycle later.
`timescale 1ns/1ps
`include "sess_defines.svh"
module sess_host_bench;
  typedef struct { logic [31:0] e; logic [31:0] m; } sess_note_t;
  localparam logic [15:0] MAKER = 16'h00c3;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        rd_q = 1'b0;
  logic [31:0] reg_rdata_o, st;
  logic        ready_busy_n, ce_n, we_n, oe_n, flash_reset_n, dq_oe;
  logic [16:0] addr, sa, sb, pa;
  logic [15:0] h_dq, m_dq;
  logic [7:0]  pd;
  wire  logic [15:0] dq_w = dq_oe ? h_dq : m_dq;
  int          err_total = 0;
  int          checked = 0;
  sess_note_t  rq[$];
  sess_note_t  wq[$];
  always #2.5 clk_i = ~clk_i;
  sess_host u_sess_host (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dq_i(dq_w), .ready_busy_n_i(ready_busy_n),
    .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .flash_reset_n_o(flash_reset_n), .addr_o(addr), .dq_o(h_dq),
    .dq_oe_o(dq_oe));
  sess_flash_model #(.MAKER(MAKER)) u_sess_flash_model (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .reset_n_i(flash_reset_n), .addr_i(addr), .dq_i(dq_w), .dq_o(m_dq), .ready_busy_n_o(ready_busy_n));
  // ------------------------------------------------------------
  // Tasks and watchers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // A zero mask marks a poll whose data only steers the bench.
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back('{e, m});
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    st = reg_rdata_o;
  endtask
  task automatic wt(input int i, input logic v, input int n);
    repeat (n) begin
      rd(`SESS_REG_STATUS, 0, 0);
      if (st[i] === v) break;
    end
    chk(st[i], v);
  endtask
  task automatic op(input logic [3:0] c);
    wr(`SESS_REG_CMD, c);
    wt(0, 1'b0, 300);
  endtask
  task automatic ew(input logic [16:0] a, input logic [7:0] d, input logic am = 1'b1);
    wq.push_back('{{7'h0, a, d}, {7'h0, {17{am}}, 8'hff}});
  endtask
  task automatic unl(input bit bm, input logic [7:0] c);
    ew(bm ? `SESS_A_B1 : `SESS_A_W1, `SESS_D_UNLOCK1);
    ew(bm ? `SESS_A_B2 : `SESS_A_W2, `SESS_D_UNLOCK2);
    ew(bm ? `SESS_A_B1 : `SESS_A_W1, c);
  endtask
  task automatic er(input bit bm, input logic [16:0] a);
    unl(bm, `SESS_D_SETUP);
    unl(bm, `SESS_D_UNLOCK1);
    void'(wq.pop_back());
    ew(a, `SESS_D_SECTOR);
    wr(`SESS_REG_ADDR, a);
    op(`SESS_OP_SERASE);
  endtask
  task automatic rdf(input logic [16:0] a, input logic [31:0] e, input logic [31:0] m);
    wr(`SESS_REG_ADDR, a);
    op(`SESS_OP_READ);
    rd(`SESS_REG_RDATA, e, m);
  endtask
  task automatic summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) rd_q <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_q && rq.size() > 0) begin
      if (rq[0].m != 0) chk(reg_rdata_o & rq[0].m, rq[0].e);
      void'(rq.pop_front());
    end
  end
  // Every write strobe on the pins must match the oldest noted write.
  always @(posedge we_n) begin
    if (!ce_n && wq.size() == 0) chk(32'h1, 32'h0);
    if (!ce_n && wq.size() > 0) begin
      chk({7'h0, addr, dq_w[7:0]} & wq[0].m, wq[0].e);
      void'(wq.pop_front());
    end
  end
  initial begin
    #400000;
    err_total++;
    summarize;
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(27));
    sa = {5'h04, 12'($urandom)};
    sb = {5'h06, 12'($urandom)};
    pa = {5'h10, 12'($urandom)};
    pd = 8'($urandom);
    repeat (4) @(posedge clk_i);
    chk(flash_reset_n, 1'b0);
    rst_i <= 1'b0;
    rd(`SESS_REG_STATUS, 32'h0, 32'h3f);
    rd(4'hf, 32'h0, 32'hffffffff);
    op(`SESS_OP_SUSPEND);
    rd(`SESS_REG_STATUS, 32'h20, 32'h20);
    $display("test reset and refusal done");
    er(0, sa);
    rd(`SESS_REG_STATUS, 32'h04, 32'h1c);
    rdf(sa, 32'h0, 32'h88);
    ew(sb, `SESS_D_SECTOR);
    wr(`SESS_REG_ADDR, sb);
    op(`SESS_OP_ADDSEC);
    ew(17'h0, `SESS_D_SUSPEND, 1'b0);
    op(`SESS_OP_SUSPEND);
    rd(`SESS_REG_STATUS, 32'h0c, 32'h0e);
    rdf(sb, 32'h80, 32'hc0);
    unl(0, `SESS_D_PROGRAM);
    ew(pa, pd);
    wr(`SESS_REG_DATA, {24'h0, pd});
    wr(`SESS_REG_ADDR, pa);
    op(`SESS_OP_PROGRAM);
    wt(1, 1'b0, 100);
    rdf(pa, {24'h0, pd}, 32'hff);
    unl(0, `SESS_D_AUTOSEL);
    op(`SESS_OP_AUTOSEL);
    rdf(17'h0, {16'h0, MAKER}, 32'hffff);
    ew(17'h0, `SESS_D_RESET, 1'b0);
    op(`SESS_OP_RESET);
    rd(`SESS_REG_STATUS, 32'h08, 32'h08);
    ew(17'h0, `SESS_D_RESUME, 1'b0);
    op(`SESS_OP_RESUME);
    rd(`SESS_REG_STATUS, 32'h0, 32'h08);
    op(`SESS_OP_RESUME);
    rd(`SESS_REG_STATUS, 32'h20, 32'h28);
    op(`SESS_OP_PROGRAM);
    op(`SESS_OP_ADDSEC);
    rd(`SESS_REG_STATUS, 32'h20, 32'h20);
    wt(2, 1'b0, 3000);
    rd(`SESS_REG_STATUS, 32'h0, 32'h0e);
    $display("test erase suspend resume done");
    wr(`SESS_REG_CFG, 32'h1);
    er(1, sb);
    wt(1, 1'b1, 10);
    ew(17'h0, `SESS_D_RESET, 1'b0);
    op(`SESS_OP_RESET);
    rd(`SESS_REG_STATUS, 32'h0, 32'h06);
    er(1, sb);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SESS_REG_STATUS, 32'h0, 32'h3f);
    chk(ready_busy_n, 1'b1);
    $display("test byte mode and reset abort done");
    summarize;
  end
endmodule
